// ---- csp_params.svh ----
// Constants for the clocked serial port guards
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH
`define CSP_CLK_SEL_RESET 8'h00
`define CSP_DATA_LEN_RESET 4'h8
`define CSP_DATA_LEN_MIN 4'h2
`define CSP_CTL0_RSVD_HI 3
`define CSP_CTL0_RSVD_LO 2
`define CSP_CTL0_RESET 8'h00
`endif

// ---- csp_pkg.sv ----
// Types for the clocked serial port guards
package csp_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_shift = 3'b010,
      st_done = 3'b100
   } link_state_t;
endpackage : csp_pkg

// ---- clocked_serial_port.sv ----
// Clocked three-wire serial port with configuration write guards
// Functional notes
// - Clock select writes accepted only when power off or both enables off.
// - Data length writes accepted only when power off or both enables off.
// - Continuous transmit mode never raises the receive-complete interrupt.
// - Single mode: transmit write while transfer in progress is dropped.
// - Clearing the power bit aborts transfer and stops the serial clock.
`timescale 1ns/1ps
`include "csp_params.svh"
module clocked_serial_port #(
   parameter int DATA_MAX = 16
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic interface_power_bit,
   input wire logic transmit_enable_bit,
   input wire logic receive_enable_bit,
   input wire logic continuous_mode,
   input wire logic ctl0_wr,
   input wire logic [7:0] ctl0_wdata,
   input wire logic clock_select_wr,
   input wire logic [7:0] clock_select_wdata,
   input wire logic data_length_wr,
   input wire logic [3:0] data_length_wdata,
   input wire logic tx_wr,
   input wire logic [DATA_MAX-1:0] tx_wdata,
   input wire logic serial_in,
   output logic [7:0] serial_control_reg0,
   output logic [7:0] clock_select_reg,
   output logic [3:0] data_length_reg,
   output logic transfer_in_progress_flag,
   output logic tx_write_dropped,
   output logic receive_complete_irq,
   output logic [DATA_MAX-1:0] rx_data,
   output logic serial_out,
   output logic serial_clk_en
);
   // The shifter needs two bits at least; the length field cannot ask for more than 16
   if (DATA_MAX < 2 || DATA_MAX > 16) begin : g_bad_data_max
      $error("DATA_MAX must be 2..16");
   end

   logic cfg_open;
   assign cfg_open = !interface_power_bit || (!transmit_enable_bit && !receive_enable_bit);

   localparam logic [7:0] CTL0_RSVD_MASK = (8'h01 << `CSP_CTL0_RSVD_HI)
      | (8'h01 << `CSP_CTL0_RSVD_LO);

   // Control register 0; reserved bits forced to zero whatever software writes
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_control_reg0 <= `CSP_CTL0_RESET;
      end else if (ctl0_wr) begin
         serial_control_reg0 <= ctl0_wdata & ~CTL0_RSVD_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         clock_select_reg <= `CSP_CLK_SEL_RESET;
      end else if (clock_select_wr && cfg_open) begin
         clock_select_reg <= clock_select_wdata;
      end
   end

   // Lengths below the minimum are replaced by the reset length so the shifter never stalls
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_length_reg <= `CSP_DATA_LEN_RESET;
      end else if (data_length_wr && cfg_open) begin
         data_length_reg <= (data_length_wdata < `CSP_DATA_LEN_MIN) ?
            `CSP_DATA_LEN_RESET : data_length_wdata;
      end
   end

   // Request/done handshake across to the link domain
   logic req_tog;
   logic [DATA_MAX-1:0] tx_hold;
   logic done_s1, done_s2, done_s3;
   logic link_done_tog;
   logic active;
   assign active = interface_power_bit && transmit_enable_bit;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_s3 <= 1'b0;
      end else begin
         done_s1 <= link_done_tog;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
      end
   end

   // Only the settled second and third flops form the edge
   logic done_evt;
   assign done_evt = done_s2 ^ done_s3;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_tog <= 1'b0;
         tx_hold <= '0;
         transfer_in_progress_flag <= 1'b0;
         tx_write_dropped <= 1'b0;
      end else begin
         tx_write_dropped <= 1'b0;
         if (!interface_power_bit) begin
            transfer_in_progress_flag <= 1'b0;
         end else begin
            if (tx_wr && active && (!transfer_in_progress_flag || continuous_mode)) begin
               // Continuous mode overwrites the holding word; no new request is raised while busy
               tx_hold <= tx_wdata;
               if (!transfer_in_progress_flag) begin
                  req_tog <= ~req_tog;
                  transfer_in_progress_flag <= 1'b1;
               end
            end else if (tx_wr && transfer_in_progress_flag) begin
               tx_write_dropped <= 1'b1;
            end
            // Completion is taken apart from the write decode, so a write in the
            // same cycle cannot swallow the one-cycle done event and hang the flag
            if (done_evt && transfer_in_progress_flag) begin
               transfer_in_progress_flag <= 1'b0;
            end
         end
      end
   end

   logic rx_done_pulse;
   assign rx_done_pulse = done_evt && interface_power_bit;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         receive_complete_irq <= 1'b0;
      end else begin
         receive_complete_irq <= rx_done_pulse && receive_enable_bit
            && !(continuous_mode && transmit_enable_bit);
      end
   end

   // Link domain
   // Release reaches the link flops on link edges only, never mid-cycle
   logic [2:0] lreset_sync;
   logic link_rst_n;
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         lreset_sync <= 3'b000;
      end else begin
         lreset_sync <= {lreset_sync[1:0], 1'b1};
      end
   end
   assign link_rst_n = lreset_sync[2];

   logic req_s1, req_s2, req_s3, pwr_s1, pwr_s2;
   csp_pkg::link_state_t state;
   logic [DATA_MAX-1:0] shift_reg;
   logic [3:0] bit_cnt;
   logic [3:0] len_link;

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
         pwr_s1 <= 1'b0;
         pwr_s2 <= 1'b0;
      end else begin
         req_s1 <= req_tog;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
         pwr_s1 <= interface_power_bit;
         pwr_s2 <= pwr_s1;
      end
   end

   // Config registers are frozen while enabled, so sampling them here is stable
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state <= csp_pkg::st_idle;
         shift_reg <= '0;
         bit_cnt <= 4'h0;
         len_link <= `CSP_DATA_LEN_RESET;
         link_done_tog <= 1'b0;
         serial_out <= 1'b0;
         serial_clk_en <= 1'b0;
         rx_data <= '0;
      end else if (!pwr_s2) begin
         state <= csp_pkg::st_idle;
         serial_clk_en <= 1'b0;
         serial_out <= 1'b0;
      end else begin
         case (state)
            csp_pkg::st_idle: begin
               // Length, and in single mode the word, have stood for several link clocks by now
               if (req_s2 ^ req_s3) begin
                  shift_reg <= tx_hold;
                  len_link <= data_length_reg;
                  bit_cnt <= 4'h0;
                  serial_clk_en <= 1'b1;
                  state <= csp_pkg::st_shift;
               end
            end
            csp_pkg::st_shift: begin
               serial_out <= shift_reg[DATA_MAX-1];
               shift_reg <= {shift_reg[DATA_MAX-2:0], serial_in};
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == len_link - 4'h1) begin
                  state <= csp_pkg::st_done;
               end
            end
            csp_pkg::st_done: begin
               serial_clk_en <= 1'b0;
               rx_data <= shift_reg;
               link_done_tog <= ~link_done_tog;
               state <= csp_pkg::st_idle;
            end
            default: state <= csp_pkg::st_idle;
         endcase
      end
   end
endmodule : clocked_serial_port

// ---- csp_properties.sv ----
// Assertions for the clocked serial port
`timescale 1ns/1ps
module csp_checker (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic interface_power_bit,
   input wire logic transmit_enable_bit,
   input wire logic receive_enable_bit,
   input wire logic continuous_mode,
   input wire logic clock_select_wr,
   input wire logic data_length_wr,
   input wire logic tx_wr,
   input wire logic [7:0] clock_select_reg,
   input wire logic [3:0] data_length_reg,
   input wire logic transfer_in_progress_flag,
   input wire logic tx_write_dropped,
   input wire logic receive_complete_irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   wire busy = interface_power_bit && (transmit_enable_bit || receive_enable_bit);
   a_clksel_guard: assert property (clock_select_wr && busy |=> $stable(clock_select_reg))
      else $error("clock select changed while busy");
   a_len_guard: assert property (data_length_wr && busy |=> $stable(data_length_reg))
      else $error("data length changed while busy");
   a_cont_no_irq: assert property (continuous_mode && transmit_enable_bit
      |=> !receive_complete_irq)
      else $error("receive irq in continuous transmit");
   a_single_drop: assert property (tx_wr && transfer_in_progress_flag && interface_power_bit
      && !continuous_mode |=> tx_write_dropped)
      else $error("busy write not dropped");
   a_power_abort: assert property (!interface_power_bit |=> !transfer_in_progress_flag)
      else $error("flag kept after power off");
   cover property (tx_write_dropped);
   cover property (receive_complete_irq);
   cover property ($fell(interface_power_bit) && transfer_in_progress_flag);
endmodule : csp_checker
bind clocked_serial_port csp_checker csp_checker_i (.ref_clk(ref_clk), .reset_n(reset_n),
   .interface_power_bit(interface_power_bit), .transmit_enable_bit(transmit_enable_bit),
   .receive_enable_bit(receive_enable_bit), .continuous_mode(continuous_mode),
   .clock_select_wr(clock_select_wr), .data_length_wr(data_length_wr), .tx_wr(tx_wr),
   .clock_select_reg(clock_select_reg), .data_length_reg(data_length_reg),
   .transfer_in_progress_flag(transfer_in_progress_flag), .tx_write_dropped(tx_write_dropped),
   .receive_complete_irq(receive_complete_irq));

// ---- csp_peer.sv ----
// Serial peer that echoes the port's own data
`timescale 1ns/1ps
module csp_peer (
   input wire logic link_clk,
   input wire logic serial_clk_en,
   input wire logic serial_out,
   output logic serial_in
);
   initial serial_in = 1'b0;
   // Line is released between frames, so it toggles rather than holding
   always @(negedge link_clk) begin
      serial_in <= serial_clk_en ? serial_out : ~serial_in;
   end
endmodule : csp_peer

// ---- tb.sv ----
// Self-checking bench for the clocked serial port
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
   typedef struct {logic [2:0] en; logic [7:0] s; logic [3:0] l;
      logic [7:0] es; logic [3:0] el;} row_t;
   row_t rows[5] = '{'{3'h3, 8'h5a, 4'h4, 8'h5a, 4'h4}, '{3'h4, 8'h33, 4'h6, 8'h33, 4'h6},
      '{3'h6, 8'h77, 4'h3, 8'h33, 4'h6}, '{3'h5, 8'h11, 4'h5, 8'h33, 4'h6},
      '{3'h3, 8'h44, 4'h1, 8'h44, 4'h8}};
   logic ref_clk = 1'b0, reset_n = 1'b0, link_clk = 1'b0, pwr = 1'b0, txe = 1'b0, rxe = 1'b0;
   logic cont = 1'b0, cs_wr = 1'b0, dl_wr = 1'b0, tx_wr = 1'b0, c0_wr = 1'b0;
   logic [7:0] cs_wd = 8'h00;
   logic [7:0] c0_wd = 8'h00;
   logic [7:0] c0r;
   logic [15:0] rx;
   logic [3:0] dl_wd = 4'h0;
   logic [15:0] tx_wd = 16'h0000;
   logic [7:0] csr;
   logic [3:0] dlr;
   logic flag, drop, irq, sin, sout, clk_en;
   int fails = 0, n_checks = 0, n_irq = 0, irq0 = 0;
   clocked_serial_port clocked_serial_port_i (.ref_clk(ref_clk), .reset_n(reset_n),
      .link_clk(link_clk), .interface_power_bit(pwr), .transmit_enable_bit(txe),
      .receive_enable_bit(rxe), .continuous_mode(cont), .ctl0_wr(c0_wr), .ctl0_wdata(c0_wd),
      .clock_select_wr(cs_wr), .clock_select_wdata(cs_wd), .data_length_wr(dl_wr),
      .data_length_wdata(dl_wd), .tx_wr(tx_wr), .tx_wdata(tx_wd), .serial_in(sin),
      .serial_control_reg0(c0r), .clock_select_reg(csr), .data_length_reg(dlr),
      .transfer_in_progress_flag(flag), .tx_write_dropped(drop), .receive_complete_irq(irq),
      .rx_data(rx), .serial_out(sout), .serial_clk_en(clk_en));
   csp_peer csp_peer_i (.link_clk(link_clk), .serial_clk_en(clk_en), .serial_out(sout),
      .serial_in(sin));
   initial forever #5 ref_clk = ~ref_clk;
   initial begin
      #3;
      forever #6 link_clk = ~link_clk;
   end
   // An unknown request counts as raised
   always @(posedge ref_clk) if (irq !== 1'b0) n_irq++;
   task results;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   task send(input logic [15:0] d);
      @(posedge ref_clk);
      tx_wr <= 1'b1;
      tx_wd <= d;
      @(posedge ref_clk);
      tx_wr <= 1'b0;
      #1;
   endtask : send
   // Bounded wait so a stuck flag ends in a mismatch, not a hang
   task wait_idle;
      for (int k = 0; k < 200 && flag !== 1'b0; k++) @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : wait_idle
   initial begin
      #20000;
      fails++;
      results();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      `CHK("len_reset", 4'h8, dlr)
      @(posedge ref_clk);
      c0_wr <= 1'b1;
      c0_wd <= 8'hb1;
      @(posedge ref_clk);
      c0_wr <= 1'b0;
      #1;
      `CHK("serial_control_reg0", 8'hb1, c0r)
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk);
         {pwr, txe, rxe} <= rows[i].en;
         cs_wr <= 1'b1;
         cs_wd <= rows[i].s;
         dl_wr <= 1'b1;
         dl_wd <= rows[i].l;
         @(posedge ref_clk);
         cs_wr <= 1'b0;
         dl_wr <= 1'b0;
         #1;
         `CHK("clock_select_reg", rows[i].es, csr)
         `CHK("data_length_reg", rows[i].el, dlr)
      end
      $display("config rows done");
      @(posedge ref_clk);
      {pwr, txe, rxe} <= 3'h7;
      irq0 = n_irq;
      send(16'ha5c3);
      `CHK("flag", 1'b1, flag)
      send(16'h0f0f);
      `CHK("dropped", 1'b1, drop)
      wait_idle();
      `CHK("irq", 1, n_irq - irq0)
      repeat (20) @(posedge ref_clk);
      #1;
      `CHK("no_resend", 1'b0, flag)
      // Echo lags one bit, so the low bits hold the word's top seven bits
      `CHK("rx_data", 7'h52, rx[6:0])
      $display("single mode done");
      @(posedge ref_clk);
      cont <= 1'b1;
      irq0 = n_irq;
      send(16'h1234);
      `CHK("cont_flag", 1'b1, flag)
      repeat (6) @(posedge ref_clk);
      send(16'h5678);
      `CHK("cont_accept", 1'b0, drop)
      wait_idle();
      `CHK("cont_irq", 0, n_irq - irq0)
      `CHK("cont_rx", 7'h09, rx[6:0])
      $display("continuous done");
      @(posedge ref_clk);
      cont <= 1'b0;
      send(16'h00ff);
      repeat (5) @(posedge ref_clk);
      #1;
      `CHK("abort_run", 1'b1, clk_en)
      @(posedge ref_clk);
      pwr <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      `CHK("abort_flag", 1'b0, flag)
      `CHK("abort_clk", 1'b0, clk_en)
      $display("abort done");
      results();
   end
endmodule : tb
